// ### bench/uira_assertions.sv
// Link and core-port checks for the indirect register access port
`timescale 1ns/100ps
module uira_assertions (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       sfr_sel,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_rvalid,
  input  wire logic [5:0] o_target_register_index,
  input  wire logic       o_core_wr,
  input  wire logic       o_core_rd,
  input  wire logic [7:0] o_core_wdata,
  input  wire logic [7:0] i_core_rdata,
  input  wire logic       i_core_ack
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic busy;
  // Busy is the core request level, so it is visible without the address register
  assign busy = o_core_wr | o_core_rd;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  rd_answer_a: assert property (sfr_rd |=> sfr_rvalid)
    else $error("read strobe not answered next cycle");
  rvalid_cause_a: assert property (sfr_rvalid |-> $past(sfr_rd))
    else $error("read valid without a read strobe");
  data_forward_a: assert property (sfr_wr && sfr_sel && !busy |=> o_core_wr && o_core_wdata == $past(sfr_wdata))
    else $error("data write not forwarded to core");
  read_start_a: assert property (sfr_wr && !sfr_sel && !busy && sfr_wdata[7]
    |=> o_core_rd && {2'h0, o_target_register_index} == ($past(sfr_wdata) & 8'h3F))
    else $error("combined index load and read start failed");
  index_keep_a: assert property (!(sfr_wr && !sfr_sel && !busy) |=> $stable(o_target_register_index))
    else $error("index changed without address write");
  request_hold_a: assert property (busy && !i_core_ack |=> $stable({o_core_wr, o_core_rd, o_core_wdata}))
    else $error("core request changed before ack");
  request_drop_a: assert property (busy && i_core_ack |=> !o_core_wr && !o_core_rd)
    else $error("core request not released after ack");
  fetch_store_a: assert property (o_core_rd && i_core_ack |=> o_core_wdata == $past(i_core_rdata))
    else $error("fetched value not stored in data register");
  busy_read_a: assert property (sfr_rd && !sfr_sel
    |=> sfr_rdata == {$past(busy), 1'b0, $past(o_target_register_index)})
    else $error("address register readback wrong");
  poll_first_a: assert property (sfr_wr |-> !busy)
    else $error("link write issued while port busy");
  data_read_idle_a: assert property (sfr_rd && sfr_sel |-> !busy)
    else $error("data register read while port busy");
  // ---------------------------------------------------------------
  // Covers
  // ---------------------------------------------------------------
  write_done_c: cover property (o_core_wr && i_core_ack);
  read_done_c: cover property (o_core_rd && i_core_ack);
  busy_seen_c: cover property (sfr_rd && !sfr_sel && busy);
endmodule

// ### bench/usb_indirect_register_access_test.sv
// Self-checking bench joining processor end and access port end
`timescale 1ns/100ps
module usb_indirect_register_access_test;
  logic       clock;
  logic       rstn;
  logic       cmd_valid;
  logic       cmd_write;
  logic [5:0] cmd_index;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic [5:0] core_index;
  logic       core_wr;
  logic       core_rd;
  logic       core_ack;
  logic [7:0] core_wdata;
  logic [7:0] core_rdata;
  logic [7:0] mem [64];
  int         ack_delay;
  int         wait_cnt;
  int         n_errors;
  int         n_tests;

  uira_sfr_if link();
  uira_host uira_host_i (.i_clock(clock), .i_rstn(rstn), .sfr(link), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_index(cmd_index), .i_cmd_wdata(cmd_wdata),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
  uira_device uira_device_i (.i_clock(clock), .i_rstn(rstn), .sfr(link),
    .o_target_register_index(core_index), .o_core_wr(core_wr), .o_core_rd(core_rd),
    .o_core_wdata(core_wdata), .i_core_rdata(core_rdata), .i_core_ack(core_ack));
  uira_assertions uira_assertions_i (.i_clock(clock), .i_rstn(rstn), .sfr_sel(link.sfr_sel),
    .sfr_wr(link.sfr_wr), .sfr_rd(link.sfr_rd), .sfr_wdata(link.sfr_wdata),
    .sfr_rdata(link.sfr_rdata), .sfr_rvalid(link.sfr_rvalid),
    .o_target_register_index(core_index), .o_core_wr(core_wr), .o_core_rd(core_rd),
    .o_core_wdata(core_wdata), .i_core_rdata(core_rdata), .i_core_ack(core_ack));

  // ---------------------------------------------------------------
  // Clock and core register file
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Core acks after ack_delay cycles; read data toggles when not acked so stale use shows
  always @(posedge clock) begin
    #1;
    if ((core_wr || core_rd) && !core_ack && wait_cnt >= ack_delay) begin
      core_ack = 1'b1;
      core_rdata = mem[core_index];
      if (core_wr) mem[core_index] = core_wdata;
    end else begin
      wait_cnt = ((core_wr || core_rd) && !core_ack) ? wait_cnt + 1 : 0;
      core_ack = 1'b0;
      core_rdata = ~core_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmd(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] got);
    int k;
    k = 0;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_index = idx;
    cmd_wdata = wd;
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 200) begin
      n_errors++;
      conclude;
    end
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 400) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 400) begin
      n_errors++;
      conclude;
    end
    got = rsp_data;
  endtask

  // The write response leaves with the data write, so the core request only rises one edge later
  task automatic wait_core;
    int k;
    k = 0;
    @(posedge clock);
    #1;
    while ((core_wr || core_rd) && k < 100) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 100) begin
      n_errors++;
      conclude;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] got;
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_index = 6'h00;
    cmd_wdata = 8'h00;
    core_ack = 1'b0;
    core_rdata = 8'h00;
    ack_delay = 0;
    wait_cnt = 0;
    n_errors = 0;
    n_tests = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (3) @(posedge clock);
    #1;
    rstn = 1'b1;
    check("data reg reset", core_wdata, 8'h00);
    check("index reset", {2'h0, core_index}, 8'h00);
    check("ready after reset", {7'h00, cmd_ready}, 8'h01);
    cmd(1'b1, 6'h05, 8'hA5, got);
    wait_core;
    check("core reg 05", mem[5], 8'hA5);
    // Slow core: back-to-back writes must wait on busy
    ack_delay = 6;
    cmd(1'b1, 6'h05, 8'h3C, got);
    @(posedge clock);
    #1;
    check("busy during write", {7'h00, core_wr}, 8'h01);
    cmd(1'b1, 6'h05, 8'h5A, got);
    wait_core;
    check("core reg 05 again", mem[5], 8'h5A);
    check("index kept", {2'h0, core_index}, 8'h05);
    cmd(1'b0, 6'h05, 8'h00, got);
    check("read 05", got, 8'h5A);
    check("data reg after read", core_wdata, 8'h5A);
    mem[5] = 8'h77;
    cmd(1'b0, 6'h05, 8'h00, got);
    check("repeat read 05", got, 8'h77);
    mem[42] = 8'hC3;
    ack_delay = 3;
    cmd(1'b0, 6'h2A, 8'h00, got);
    check("read 2A", got, 8'hC3);
    check("index 2A", {2'h0, core_index}, 8'h2A);
    ack_delay = 0;
    cmd(1'b1, 6'h3F, 8'hFF, got);
    check("index 3F", {2'h0, core_index}, 8'h3F);
    cmd(1'b0, 6'h3F, 8'h00, got);
    check("read 3F", got, 8'hFF);
    conclude;
  end
endmodule

// ### common/uira_pkg.sv
// Shared constants and types for the indirect register access port
package uira_pkg;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned INDEX_W     = 6;
  localparam int unsigned BUSY_BIT    = 7;
  localparam int unsigned AUTORD_BIT  = 6;
  localparam int unsigned INDEX_MSB   = 5;
  localparam int unsigned INDEX_LSB   = 0;

  // ---------------------------------------------------------------
  // Register select codes and reset values
  // ---------------------------------------------------------------
  localparam logic        SEL_ADDRESS = 1'h0;
  localparam logic        SEL_DATA    = 1'h1;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [7:0]  ADDR_RESET  = 8'h00;
  localparam logic [5:0]  INDEX_RESET = 6'h00;
  localparam logic [7:0]  START_READ  = 8'h80;
  localparam logic [7:0]  BUSY_MASK   = 8'h80;

  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    UIRA_DEV_IDLE  = 3'b001,
    UIRA_DEV_WRITE = 3'b010,
    UIRA_DEV_READ  = 3'b100
  } uira_dev_st_e;

  typedef enum logic [5:0] {
    UIRA_HOST_IDLE       = 6'b000001,
    UIRA_HOST_PRE_WAIT   = 6'b000010,
    UIRA_HOST_LOADED     = 6'b000100,
    UIRA_HOST_ARM        = 6'b001000,
    UIRA_HOST_POST_WAIT  = 6'b010000,
    UIRA_HOST_FETCH_WAIT = 6'b100000
  } uira_host_st_e;

endpackage

// ### common/uira_sfr_if.sv
// Special function register link between processor and access port
`timescale 1ns/100ps
interface uira_sfr_if;

  // ---------------------------------------------------------------
  // Link signals
  // ---------------------------------------------------------------
  logic       sfr_sel;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       sfr_rvalid;

  // ---------------------------------------------------------------
  // Party views
  // ---------------------------------------------------------------
  modport host (
    output sfr_sel,
    output sfr_wr,
    output sfr_rd,
    output sfr_wdata,
    input  sfr_rdata,
    input  sfr_rvalid
  );

  modport device (
    input  sfr_sel,
    input  sfr_wr,
    input  sfr_rd,
    input  sfr_wdata,
    output sfr_rdata,
    output sfr_rvalid
  );

endinterface

// ### rtl/uira_device.sv
// Access port end: address and data registers forwarding to the core
`timescale 1ns/100ps
module uira_device (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  uira_sfr_if.device      sfr,
  output logic [5:0]      o_target_register_index,
  output logic            o_core_wr,
  output logic            o_core_rd,
  output logic [7:0]      o_core_wdata,
  input  wire logic [7:0] i_core_rdata,
  input  wire logic       i_core_ack
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    uira_pkg::uira_dev_st_e st;
    logic [5:0]             index;
    logic                   busy;
    logic [7:0]             indirect_data_reg;
    logic                   core_wr;
    logic                   core_rd;
    logic [7:0]             rdata;
    logic                   rvalid;
  } uira_dev_s;

  uira_dev_s r;
  uira_dev_s next_r;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.rvalid = 1'b0;
    unique case (r.st)
      uira_pkg::UIRA_DEV_IDLE: begin
        if (sfr.sfr_wr && sfr.sfr_sel == uira_pkg::SEL_ADDRESS) begin
          next_r.index = sfr.sfr_wdata[uira_pkg::INDEX_MSB:uira_pkg::INDEX_LSB];
          if (sfr.sfr_wdata[uira_pkg::BUSY_BIT]) begin
            next_r.st      = uira_pkg::UIRA_DEV_READ;
            next_r.busy    = 1'b1;
            next_r.core_rd = 1'b1;
          end
        end else if (sfr.sfr_wr) begin
          next_r.indirect_data_reg = sfr.sfr_wdata;
          next_r.st                = uira_pkg::UIRA_DEV_WRITE;
          next_r.busy              = 1'b1;
          next_r.core_wr           = 1'b1;
        end
      end
      uira_pkg::UIRA_DEV_WRITE: begin
        if (i_core_ack) begin
          next_r.st      = uira_pkg::UIRA_DEV_IDLE;
          next_r.busy    = 1'b0;
          next_r.core_wr = 1'b0;
        end
      end
      uira_pkg::UIRA_DEV_READ: begin
        if (i_core_ack) begin
          next_r.indirect_data_reg = i_core_rdata;
          next_r.st                = uira_pkg::UIRA_DEV_IDLE;
          next_r.busy              = 1'b0;
          next_r.core_rd           = 1'b0;
        end
      end
    endcase
    // Writes while busy are dropped; the processor must poll first
    if (sfr.sfr_rd) begin
      next_r.rvalid = 1'b1;
      if (sfr.sfr_sel == uira_pkg::SEL_ADDRESS) begin
        next_r.rdata                       = uira_pkg::ADDR_RESET;
        next_r.rdata[uira_pkg::BUSY_BIT]   = r.busy;
        next_r.rdata[uira_pkg::INDEX_MSB:uira_pkg::INDEX_LSB] = r.index;
      end else begin
        next_r.rdata = r.indirect_data_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      r.st                <= uira_pkg::UIRA_DEV_IDLE;
      r.index             <= uira_pkg::INDEX_RESET;
      r.busy              <= 1'b0;
      r.indirect_data_reg <= uira_pkg::DATA_RESET;
      r.core_wr           <= 1'b0;
      r.core_rd           <= 1'b0;
      r.rdata             <= uira_pkg::DATA_RESET;
      r.rvalid            <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sfr.sfr_rdata             = r.rdata;
  assign sfr.sfr_rvalid            = r.rvalid;
  assign o_target_register_index   = r.index;
  assign o_core_wr                 = r.core_wr;
  assign o_core_rd                 = r.core_rd;
  assign o_core_wdata              = r.indirect_data_reg;

endmodule

// ### rtl/uira_host.sv
// Processor end: runs the poll, load, write and read procedures
`timescale 1ns/100ps
module uira_host (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  uira_sfr_if.host        sfr,
  input  wire logic       i_cmd_valid,
  input  wire logic       i_cmd_write,
  input  wire logic [5:0] i_cmd_index,
  input  wire logic [7:0] i_cmd_wdata,
  output logic            o_cmd_ready,
  output logic            o_rsp_valid,
  output logic [7:0]      o_rsp_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    uira_pkg::uira_host_st_e st;
    logic                    cmd_write;
    logic [5:0]              index;
    logic [7:0]              wdata;
    logic [5:0]              last_index;
    logic                    last_valid;
    logic                    sfr_sel;
    logic                    sfr_wr;
    logic                    sfr_rd;
    logic [7:0]              sfr_wdata;
    logic                    ready;
    logic                    rsp_valid;
    logic [7:0]              rsp_data;
  } uira_host_s;

  uira_host_s r;
  uira_host_s next_r;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] addr_word(input logic start, input logic [5:0] idx);
    logic [7:0] w;
    w                                           = uira_pkg::ADDR_RESET;
    w[uira_pkg::BUSY_BIT]                       = start;
    w[uira_pkg::INDEX_MSB:uira_pkg::INDEX_LSB]  = idx;
    return w;
  endfunction

  function automatic logic busy_of(input logic [7:0] w);
    return (w & uira_pkg::BUSY_MASK) != uira_pkg::ADDR_RESET;
  endfunction

  logic index_same;
  assign index_same = r.last_valid && (r.last_index == r.index);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r           = r;
    next_r.sfr_wr    = 1'b0;
    next_r.sfr_rd    = 1'b0;
    next_r.rsp_valid = 1'b0;
    unique case (r.st)
      uira_pkg::UIRA_HOST_IDLE: begin
        if (i_cmd_valid && r.ready) begin
          next_r.cmd_write = i_cmd_write;
          next_r.index     = i_cmd_index;
          next_r.wdata     = i_cmd_wdata;
          next_r.ready     = 1'b0;
          next_r.sfr_sel   = uira_pkg::SEL_ADDRESS;
          next_r.sfr_rd    = 1'b1;
          next_r.st        = uira_pkg::UIRA_HOST_PRE_WAIT;
        end
      end
      uira_pkg::UIRA_HOST_PRE_WAIT: begin
        if (sfr.sfr_rvalid) begin
          if (busy_of(sfr.sfr_rdata)) begin
            next_r.sfr_sel = uira_pkg::SEL_ADDRESS;
            next_r.sfr_rd  = 1'b1;
          end else if (r.cmd_write && index_same) begin
            next_r.sfr_sel   = uira_pkg::SEL_DATA;
            next_r.sfr_wdata = r.wdata;
            next_r.sfr_wr    = 1'b1;
            next_r.rsp_valid = 1'b1;
            next_r.ready     = 1'b1;
            next_r.st        = uira_pkg::UIRA_HOST_IDLE;
          end else if (r.cmd_write) begin
            next_r.sfr_sel    = uira_pkg::SEL_ADDRESS;
            next_r.sfr_wdata  = addr_word(1'b0, r.index);
            next_r.sfr_wr     = 1'b1;
            next_r.last_index = r.index;
            next_r.last_valid = 1'b1;
            next_r.st         = uira_pkg::UIRA_HOST_LOADED;
          end else begin
            // index and start in one write
            next_r.sfr_sel    = uira_pkg::SEL_ADDRESS;
            next_r.sfr_wdata  = addr_word(1'b1, r.index);
            next_r.sfr_wr     = 1'b1;
            next_r.last_index = r.index;
            next_r.last_valid = 1'b1;
            next_r.st         = uira_pkg::UIRA_HOST_ARM;
          end
        end
      end
      uira_pkg::UIRA_HOST_LOADED: begin
        next_r.sfr_sel   = uira_pkg::SEL_DATA;
        next_r.sfr_wdata = r.wdata;
        next_r.sfr_wr    = 1'b1;
        next_r.rsp_valid = 1'b1;
        next_r.ready     = 1'b1;
        next_r.st        = uira_pkg::UIRA_HOST_IDLE;
      end
      uira_pkg::UIRA_HOST_ARM: begin
        next_r.sfr_sel = uira_pkg::SEL_ADDRESS;
        next_r.sfr_rd  = 1'b1;
        next_r.st      = uira_pkg::UIRA_HOST_POST_WAIT;
      end
      uira_pkg::UIRA_HOST_POST_WAIT: begin
        if (sfr.sfr_rvalid) begin
          if (busy_of(sfr.sfr_rdata)) begin
            next_r.sfr_sel = uira_pkg::SEL_ADDRESS;
            next_r.sfr_rd  = 1'b1;
          end else begin
            // data read only after busy clear
            next_r.sfr_sel = uira_pkg::SEL_DATA;
            next_r.sfr_rd  = 1'b1;
            next_r.st      = uira_pkg::UIRA_HOST_FETCH_WAIT;
          end
        end
      end
      uira_pkg::UIRA_HOST_FETCH_WAIT: begin
        if (sfr.sfr_rvalid) begin
          next_r.rsp_data  = sfr.sfr_rdata;
          next_r.rsp_valid = 1'b1;
          next_r.ready     = 1'b1;
          next_r.st        = uira_pkg::UIRA_HOST_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Remembered index assumes no other master moves the port index
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      r.st         <= uira_pkg::UIRA_HOST_IDLE;
      r.cmd_write  <= 1'b0;
      r.index      <= uira_pkg::INDEX_RESET;
      r.wdata      <= uira_pkg::DATA_RESET;
      r.last_index <= uira_pkg::INDEX_RESET;
      r.last_valid <= 1'b0;
      r.sfr_sel    <= uira_pkg::SEL_ADDRESS;
      r.sfr_wr     <= 1'b0;
      r.sfr_rd     <= 1'b0;
      r.sfr_wdata  <= uira_pkg::DATA_RESET;
      r.ready      <= 1'b1;
      r.rsp_valid  <= 1'b0;
      r.rsp_data   <= uira_pkg::DATA_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign sfr.sfr_sel   = r.sfr_sel;
  assign sfr.sfr_wr    = r.sfr_wr;
  assign sfr.sfr_rd    = r.sfr_rd;
  assign sfr.sfr_wdata = r.sfr_wdata;
  assign o_cmd_ready   = r.ready;
  assign o_rsp_valid   = r.rsp_valid;
  assign o_rsp_data    = r.rsp_data;

endmodule
